/* include/ppc_pkg.sv */
// ==========================================================================
// Shared constants for the port pin configuration block
// ==========================================================================
package ppc_pkg;

    // ======================================================================
    // Widths
    // ======================================================================
    localparam int PIN_N = 32;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // ======================================================================
    // Register byte offsets
    // ======================================================================
    localparam logic [4:0] OFS_ROUTER_CFG2 = 5'h00;
    localparam logic [4:0] OFS_PORT3_IRQ = 5'h04;
    localparam logic [4:0] OFS_OUT_MODE = 5'h08;
    localparam logic [4:0] OFS_PORT_DATA = 5'h0C;
    localparam logic [4:0] OFS_P1_IN_MODE = 5'h10;
    localparam logic [4:0] OFS_PIN_LEVEL = 5'h14;
    localparam logic [4:0] OFS_RMW_LATCH = 5'h18;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h1C;

    // ======================================================================
    // Field positions
    // ======================================================================
    localparam int BIT_PULLUP_GDIS = 7;
    localparam int BIT_ROUTER_EN = 6;
    localparam int BIT_MEMIF_RESERVE = 1;
    localparam int BIT_MEMIF_MUX = 0;
    localparam int BIT_EDGE7_FLAG = 7;
    localparam int BIT_EDGE6_FLAG = 6;
    localparam int BIT_EDGE7_POL = 3;
    localparam int BIT_EDGE6_POL = 2;
    localparam int BIT_EDGE6_EN = 0;
    localparam int BIT_EDGE7_EN = 1;
    localparam int PIN_EDGE6 = 30;
    localparam int PIN_EDGE7 = 31;
    localparam int P1_LSB = 8;

    // ======================================================================
    // Reset values
    // ======================================================================
    localparam logic [7:0] RST_ROUTER_CFG2 = 8'h00;
    localparam logic [31:0] RST_OUT_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_PORT_DATA = 32'hFFFF_FFFF;
    localparam logic [7:0] RST_P1_IN_MODE = 8'hFF;
    localparam logic [1:0] RST_POL = 2'h0;
    localparam logic [1:0] RST_EN = 2'h0;

    // ======================================================================
    // Pin groups
    // ======================================================================
    localparam logic [7:0] P0_RESERVE_NONMUX = 8'hC0;
    localparam logic [7:0] P0_RESERVE_MUX = 8'hE0;
    localparam logic [31:0] DATA_BUS_MASK = 32'hFF00_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

/* include/ppc_edge_if.sv */
`timescale 1ns/1ps
// ==========================================================================
// Edge detector hookup
// ==========================================================================
interface ppc_edge_if;
    logic raw;
    logic polarity;
    logic edge_seen;

    modport det (input raw, input polarity, output edge_seen);
    modport ctl (output raw, output polarity, input edge_seen);
endinterface

/* src/ppc_edge_det.sv */
`timescale 1ns/1ps
// ==========================================================================
// Synchronised edge detector, polarity 0 falling, 1 rising
// ==========================================================================
module ppc_edge_det (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    ppc_edge_if.det eif
);
    logic sync_a;
    logic sync_b;
    logic prev;
    logic next_edge;

    // Two-stage synchroniser then history flop
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            prev <= 1'b1;
        end else begin
            sync_a <= eif.raw;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    // Selected edge, one-cycle pulse
    assign next_edge = eif.polarity ? (sync_b & ~prev) : (~sync_b & prev);
    assign eif.edge_seen = next_edge;
endmodule

/* src/ppc_pin_cell.sv */
`timescale 1ns/1ps
// ==========================================================================
// One port pin: driver, pull-up and digital input path
// ==========================================================================
module ppc_pin_cell (
    input wire logic router_en_i,
    input wire logic latch_i,
    input wire logic push_pull_i,
    input wire logic periph_own_i,
    input wire logic periph_out_i,
    input wire logic in_assign_i,
    input wire logic memif_ovr_i,
    input wire logic memif_out_i,
    input wire logic memif_rd_off_i,
    input wire logic analog_i,
    input wire logic pullup_gdis_i,
    input wire logic pad_i,
    output wire logic out_o,
    output wire logic oe_o,
    output wire logic pullup_o,
    output wire logic din_o
);
    wire logic val;
    wire logic mode_oe;
    wire logic block_oe;

    // Output value source: memory interface, then peripheral, then latch
    assign val = memif_ovr_i ? memif_out_i :
                 (periph_own_i ? periph_out_i : latch_i);

    // Push-pull always drives, open-drain only drives a low
    assign mode_oe = push_pull_i | ~val;

    // Driver disables; analog mode deliberately not among them
    assign block_oe = ~router_en_i |
                      (in_assign_i & ~memif_ovr_i) |
                      memif_rd_off_i;

    assign oe_o = mode_oe & ~block_oe;
    assign out_o = val;

    // Pull-up off when globally disabled, analog, or driving low
    assign pullup_o = ~pullup_gdis_i & ~analog_i & ~(oe_o & ~val);

    // Analog pins read as zero
    assign din_o = pad_i & ~analog_i;
endmodule

/* src/ppc_top.sv */
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Open-drain mode with latch one leaves the pin undriven, a digital input.
// - Pins the router gives to peripheral inputs have their driver off unless the memory interface owns them.
// - P3.6 and P3.7 raise edge interrupts, polarity bit picks rising or falling.
// - A selected edge on either pin sets that pin's flag.
// - A set flag whose enable is on raises an interrupt request.
// - Pull-ups on after reset; global disable bit turns all off.
// - A pin driving low has its pull-up switched off.
// - Port 1 input mode bit zero selects analog; all default digital.
// - Analog pins block the digital path and read back zero.
// - Analog mode removes the pull-up regardless of the global bit.
// - The router skips Port 1 analog pins for digital peripherals.
// - Analog mode leaves the output driver enabled.
// - Memory reserve keeps P0.7, P0.6 and in mux mode P0.5 off the router.
// - During off-chip moves with memory reserve set the memory interface owns affected pin outputs.
// - Memory activity keeps output modes; reads disable data bus drivers.
// - All port drivers stay off until router enable is set.
// - Mode bit one is push-pull, zero open-drain.
// - Data reads give pin level; read-modify-write reads give the latch.
module ppc_top (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [ppc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [ppc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [ppc_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Pads
    input wire logic [ppc_pkg::PIN_N-1:0] pad_i,
    output logic [ppc_pkg::PIN_N-1:0] pad_o,
    output logic [ppc_pkg::PIN_N-1:0] pad_oe_o,
    output logic [ppc_pkg::PIN_N-1:0] pullup_en_o,
    // Peripheral router
    input wire logic [ppc_pkg::PIN_N-1:0] periph_out_en_i,
    input wire logic [ppc_pkg::PIN_N-1:0] periph_out_i,
    input wire logic [ppc_pkg::PIN_N-1:0] periph_in_assign_i,
    output logic [ppc_pkg::PIN_N-1:0] router_eligible_o,
    // External memory interface
    input wire logic memif_active_i,
    input wire logic memif_read_i,
    input wire logic [ppc_pkg::PIN_N-1:0] memif_pin_en_i,
    input wire logic [ppc_pkg::PIN_N-1:0] memif_out_i,
    // Interrupt requests
    output logic edge6_irq_o,
    output logic edge7_irq_o
);
    // ======================================================================
    // Register state
    // ======================================================================
    logic [7:0] router_config_reg2;
    logic [1:0] edge_polarity;
    logic edge6_irq_flag;
    logic edge7_irq_flag;
    logic [1:0] irq_enable;
    logic [ppc_pkg::PIN_N-1:0] port_output_mode_reg;
    logic [ppc_pkg::PIN_N-1:0] port_latch;
    logic [7:0] port1_input_mode_reg;

    // ======================================================================
    // Bus decode
    // ======================================================================
    wire logic wr_acc;
    wire logic rd_start;
    wire logic [31:0] be_mask;
    wire logic sel_cfg2;
    wire logic sel_p3irq;
    wire logic sel_mode;
    wire logic sel_data;
    wire logic sel_inmode;
    wire logic sel_level;
    wire logic sel_rmw;
    wire logic sel_irqen;
    wire logic [31:0] rd_mux;
    wire logic [7:0] port3_irq_reg;

    // Write lands at the edge where waitrequest is seen low
    assign wr_acc = avs_write_i & ~avs_waitrequest_o;
    assign rd_start = avs_read_i & avs_waitrequest_o;

    // Byte lanes to bit mask
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    assign sel_cfg2 = (avs_address_i == ppc_pkg::OFS_ROUTER_CFG2);
    assign sel_p3irq = (avs_address_i == ppc_pkg::OFS_PORT3_IRQ);
    assign sel_mode = (avs_address_i == ppc_pkg::OFS_OUT_MODE);
    assign sel_data = (avs_address_i == ppc_pkg::OFS_PORT_DATA);
    assign sel_inmode = (avs_address_i == ppc_pkg::OFS_P1_IN_MODE);
    assign sel_level = (avs_address_i == ppc_pkg::OFS_PIN_LEVEL);
    assign sel_rmw = (avs_address_i == ppc_pkg::OFS_RMW_LATCH);
    assign sel_irqen = (avs_address_i == ppc_pkg::OFS_IRQ_ENABLE);

    // ======================================================================
    // Derived control
    // ======================================================================
    wire logic router_enable;
    wire logic pullup_global_disable;
    wire logic memif_low_port_reserve;
    wire logic memif_mux_mode;
    wire logic [7:0] p0_reserved;
    wire logic [ppc_pkg::PIN_N-1:0] skip;
    wire logic [ppc_pkg::PIN_N-1:0] eligible;
    wire logic [ppc_pkg::PIN_N-1:0] analog;
    wire logic [ppc_pkg::PIN_N-1:0] memif_ovr;
    wire logic [ppc_pkg::PIN_N-1:0] memif_rd_off;
    wire logic [ppc_pkg::PIN_N-1:0] next_pad;
    wire logic [ppc_pkg::PIN_N-1:0] next_oe;
    wire logic [ppc_pkg::PIN_N-1:0] next_pullup;
    wire logic [ppc_pkg::PIN_N-1:0] din;

    assign router_enable = router_config_reg2[ppc_pkg::BIT_ROUTER_EN];
    assign pullup_global_disable = router_config_reg2[ppc_pkg::BIT_PULLUP_GDIS];
    assign memif_low_port_reserve = router_config_reg2[ppc_pkg::BIT_MEMIF_RESERVE];
    assign memif_mux_mode = router_config_reg2[ppc_pkg::BIT_MEMIF_MUX];

    // Port 0 pins held back for the memory strobes
    assign p0_reserved = ~memif_low_port_reserve ? 8'h00 :
                         (memif_mux_mode ? ppc_pkg::P0_RESERVE_MUX :
                          ppc_pkg::P0_RESERVE_NONMUX);

    // Port 1 analog pins, other ports never analog
    assign analog = {16'h0000, ~port1_input_mode_reg, 8'h00};

    // Pins the router must pass over
    assign skip = {16'h0000, ~port1_input_mode_reg, p0_reserved};
    assign eligible = ~skip;

    // Memory interface takes affected pins only when on the low ports
    assign memif_ovr = (memif_low_port_reserve & memif_active_i) ?
                       memif_pin_en_i : ppc_pkg::ZERO_WORD;
    assign memif_rd_off = memif_read_i ? (memif_ovr & ppc_pkg::DATA_BUS_MASK) :
                          ppc_pkg::ZERO_WORD;

    // ======================================================================
    // Pin cells
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < ppc_pkg::PIN_N; gi = gi + 1) begin : g_pin
            ppc_pin_cell u_cell (
                .router_en_i(router_enable),
                .latch_i(port_latch[gi]),
                .push_pull_i(port_output_mode_reg[gi]),
                .periph_own_i(periph_out_en_i[gi] & eligible[gi]),
                .periph_out_i(periph_out_i[gi]),
                .in_assign_i(periph_in_assign_i[gi] & eligible[gi]),
                .memif_ovr_i(memif_ovr[gi]),
                .memif_out_i(memif_out_i[gi]),
                .memif_rd_off_i(memif_rd_off[gi]),
                .analog_i(analog[gi]),
                .pullup_gdis_i(pullup_global_disable),
                .pad_i(pad_i[gi]),
                .out_o(next_pad[gi]),
                .oe_o(next_oe[gi]),
                .pullup_o(next_pullup[gi]),
                .din_o(din[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Edge interrupt pins
    // ======================================================================
    ppc_edge_if eif6 ();
    ppc_edge_if eif7 ();

    assign eif6.raw = pad_i[ppc_pkg::PIN_EDGE6];
    assign eif6.polarity = edge_polarity[0];
    assign eif7.raw = pad_i[ppc_pkg::PIN_EDGE7];
    assign eif7.polarity = edge_polarity[1];

    ppc_edge_det u_edge6 (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .eif(eif6)
    );

    ppc_edge_det u_edge7 (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .eif(eif7)
    );

    // Flag clears: byte lane 0 written with the flag bit at zero
    wire logic clr6;
    wire logic clr7;
    wire logic next_flag6;
    wire logic next_flag7;

    assign clr6 = wr_acc & sel_p3irq & avs_byteenable_i[0] &
                  ~avs_writedata_i[ppc_pkg::BIT_EDGE6_FLAG];
    assign clr7 = wr_acc & sel_p3irq & avs_byteenable_i[0] &
                  ~avs_writedata_i[ppc_pkg::BIT_EDGE7_FLAG];

    // New edge wins over a clear in the same cycle
    assign next_flag6 = eif6.edge_seen | (edge6_irq_flag & ~clr6);
    assign next_flag7 = eif7.edge_seen | (edge7_irq_flag & ~clr7);

    assign port3_irq_reg = {edge7_irq_flag, edge6_irq_flag, 2'h0,
                            edge_polarity[1], edge_polarity[0], 2'h0};

    // ======================================================================
    // Read data selection
    // ======================================================================
    assign rd_mux = sel_cfg2 ? {24'h000000, router_config_reg2} :
                    sel_p3irq ? {24'h000000, port3_irq_reg} :
                    sel_mode ? port_output_mode_reg :
                    sel_data ? din :
                    sel_inmode ? {24'h000000, port1_input_mode_reg} :
                    sel_level ? din :
                    sel_rmw ? port_latch :
                    sel_irqen ? {30'h00000000, irq_enable} :
                    ppc_pkg::ZERO_WORD;

    // ======================================================================
    // Bus handshake: one wait cycle per access
    // ======================================================================
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= ppc_pkg::ZERO_WORD;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
            if (rd_start) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // ======================================================================
    // Configuration registers
    // ======================================================================
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            router_config_reg2 <= ppc_pkg::RST_ROUTER_CFG2;
            edge_polarity <= ppc_pkg::RST_POL;
            irq_enable <= ppc_pkg::RST_EN;
        end else if (wr_acc & avs_byteenable_i[0]) begin
            if (sel_cfg2) begin
                router_config_reg2 <= avs_writedata_i[7:0];
            end
            if (sel_p3irq) begin
                edge_polarity <= {avs_writedata_i[ppc_pkg::BIT_EDGE7_POL],
                                  avs_writedata_i[ppc_pkg::BIT_EDGE6_POL]};
            end
            if (sel_irqen) begin
                irq_enable <= {avs_writedata_i[ppc_pkg::BIT_EDGE7_EN],
                               avs_writedata_i[ppc_pkg::BIT_EDGE6_EN]};
            end
        end
    end

    // Port mode, data latch and Port 1 input mode
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            port_output_mode_reg <= ppc_pkg::RST_OUT_MODE;
            port_latch <= ppc_pkg::RST_PORT_DATA;
            port1_input_mode_reg <= ppc_pkg::RST_P1_IN_MODE;
        end else if (wr_acc) begin
            if (sel_mode) begin
                port_output_mode_reg <= (port_output_mode_reg & ~be_mask) |
                                        (avs_writedata_i & be_mask);
            end
            if (sel_data | sel_rmw) begin
                port_latch <= (port_latch & ~be_mask) | (avs_writedata_i & be_mask);
            end
            if (sel_inmode & avs_byteenable_i[0]) begin
                port1_input_mode_reg <= avs_writedata_i[7:0];
            end
        end
    end

    // ======================================================================
    // Flags and registered outputs
    // ======================================================================
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            edge6_irq_flag <= 1'b0;
            edge7_irq_flag <= 1'b0;
            edge6_irq_o <= 1'b0;
            edge7_irq_o <= 1'b0;
        end else begin
            edge6_irq_flag <= next_flag6;
            edge7_irq_flag <= next_flag7;
            edge6_irq_o <= edge6_irq_flag & irq_enable[0];
            edge7_irq_o <= edge7_irq_flag & irq_enable[1];
        end
    end

    // Pad drive, enable, pull-up and router eligibility
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pad_o <= ppc_pkg::ZERO_WORD;
            pad_oe_o <= ppc_pkg::ZERO_WORD;
            pullup_en_o <= ~ppc_pkg::ZERO_WORD;
            router_eligible_o <= ppc_pkg::ZERO_WORD;
        end else begin
            pad_o <= next_pad;
            pad_oe_o <= next_oe;
            pullup_en_o <= next_pullup;
            router_eligible_o <= eligible;
        end
    end
endmodule

/* dv/ppc_props.sv */
`timescale 1ns/1ps
// ==========================================
// Port pin block checker
module ppc_props (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input logic avs_waitrequest_o,
    input wire logic [31:0] pad_i,
    input logic [31:0] pad_o,
    input logic [31:0] pad_oe_o,
    input logic [31:0] pullup_en_o,
    input wire logic [31:0] periph_in_assign_i,
    input logic [31:0] router_eligible_o,
    input wire logic memif_active_i,
    input logic edge6_irq_o,
    input logic edge7_irq_o
);
    logic [5:0] h6;
    logic [5:0] h7;
    // Recent levels of the edge pins
    always_ff @(posedge ref_clk_i) begin
        h6 <= {h6[4:0], pad_i[30]};
        h7 <= {h7[4:0], pad_i[31]};
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // One wait state, then back high
    sequence s_ans;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_bus;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ans;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
    property p_rst_oe;
        $rose(nrst_i) |-> (pad_oe_o == 32'h0) [*3];
    endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("driver on after reset");
    property p_rst_pu;
        $rose(nrst_i) |-> pullup_en_o == 32'hFFFF_FFFF && router_eligible_o == 32'h0;
    endproperty
    a_rst_pu: assert property (p_rst_pu) else $error("pull-ups off after reset");
    property p_in_off;
        !memif_active_i |=> (pad_oe_o & $past(periph_in_assign_i)) == 32'h0;
    endproperty
    a_in_off: assert property (p_in_off) else $error("input pin driven");
    property p_pu_low;
        (pullup_en_o & pad_oe_o & ~pad_o) == 32'h0;
    endproperty
    a_pu_low: assert property (p_pu_low) else $error("pull-up on a low pin");
    property p_irq6;
        $rose(edge6_irq_o) |-> h6[5:2] != {4{h6[2]}} || $past(avs_write_i, 2);
    endproperty
    a_irq6: assert property (p_irq6) else $error("irq6 without edge");
    property p_irq7;
        $rose(edge7_irq_o) |-> h7[5:2] != {4{h7[2]}} || $past(avs_write_i, 2);
    endproperty
    a_irq7: assert property (p_irq7) else $error("irq7 without edge");
    property p_hold6;
        $fell(edge6_irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
    endproperty
    a_hold6: assert property (p_hold6) else $error("irq6 dropped alone");
    property p_hold7;
        $fell(edge7_irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
    endproperty
    a_hold7: assert property (p_hold7) else $error("irq7 dropped alone");
endmodule
bind ppc_top ppc_props ppc_props_inst (.ref_clk_i, .nrst_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .pad_i, .pad_o, .pad_oe_o, .pullup_en_o, .periph_in_assign_i,
    .router_eligible_o, .memif_active_i, .edge6_irq_o, .edge7_irq_o);

/* dv/ppc_pin_model.sv */
`timescale 1ns/1ps
// ==========================================
// Pads: device driver, outside driver, pull-up
module ppc_pin_model (
    input wire logic ref_clk_i,
    input wire logic [31:0] drv_val_i,
    input wire logic [31:0] drv_en_i,
    input wire logic [31:0] pullup_i,
    input wire logic [31:0] ext_en_i,
    input wire logic [31:0] ext_val_i,
    output logic [31:0] level_o
);
    logic wander = 1'b0;
    // Floating pins change every cycle
    always_ff @(posedge ref_clk_i) begin
        wander <= ~wander;
    end
    // Wire level seen by the device
    assign level_o = (drv_en_i & drv_val_i) | (~drv_en_i & ext_en_i & ext_val_i)
        | (~drv_en_i & ~ext_en_i & (pullup_i | {32{wander}}));
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// Port pin block testbench
module tb_top;
    logic ref_clk_i, nrst_i, avs_read_i, avs_write_i, memif_active_i, memif_read_i;
    logic avs_waitrequest_o, edge6_irq_o, edge7_irq_o;
    logic [4:0] avs_address_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, pad_i, pad_o, pad_oe_o, pullup_en_o;
    logic [31:0] periph_out_en_i, periph_out_i, periph_in_assign_i, router_eligible_o;
    logic [31:0] memif_pin_en_i, memif_out_i, ext_en, ext_val, rd, lat;
    int fails, checked;
    ppc_top ppc_top_inst (.ref_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pad_i,
        .pad_o, .pad_oe_o, .pullup_en_o, .periph_out_en_i, .periph_out_i, .periph_in_assign_i,
        .router_eligible_o, .memif_active_i, .memif_read_i, .memif_pin_en_i, .memif_out_i,
        .edge6_irq_o, .edge7_irq_o);
    ppc_pin_model ppc_pin_model_inst (.ref_clk_i(ref_clk_i), .drv_val_i(pad_o),
        .drv_en_i(pad_oe_o), .pullup_i(pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .level_o(pad_i));
    // Clock, 4 ns
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task settle;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task irq_scn;
        int p, k;
        wr(5'h00, 32'h40);
        settle;
        chk(pad_oe_o, 32'h0);
        wr(5'h1C, 32'h3);
        ext_en <= 32'hC000_0000;
        for (p = 0; p < 2; p++) begin
            for (k = 0; k < 2; k++) begin
                // Opposite polarity while moving to the start level
                wr(5'h04, p ? 32'h0 : 32'h0C);
                ext_val[30+k] <= p[0];
                repeat (8) @(posedge ref_clk_i);
                wr(5'h04, p ? 32'h0C : 32'h0);
                ext_val[30+k] <= !p[0];
                repeat (8) @(posedge ref_clk_i);
                chk({30'h0, edge7_irq_o, edge6_irq_o}, 32'h0);
                ext_val[30+k] <= p[0];
                for (int n = 0; n < 12 && (edge6_irq_o | edge7_irq_o) !== 1'b1; n++) begin
                    @(posedge ref_clk_i);
                end
                chk({30'h0, edge7_irq_o, edge6_irq_o}, 32'h1 << k);
                rdc(5'h04, (p ? 32'h0C : 32'h0) | (32'h40 << k));
                wr(5'h1C, 32'h0);
                settle;
                chk({30'h0, edge7_irq_o, edge6_irq_o}, 32'h0);
                wr(5'h1C, 32'h3);
                settle;
                chk({30'h0, edge7_irq_o, edge6_irq_o}, 32'h1 << k);
            end
        end
        wr(5'h1C, 32'h0);
        ext_en <= 32'h0;
    endtask
    task pin_scn;
        lat = 32'h3CFF_A50F;
        wr(5'h18, lat);
        settle;
        chk(pad_oe_o, ~lat);
        chk(pullup_en_o, lat);
        rdc(5'h0C, lat);
        wr(5'h08, 32'hFFFF_FFFF);
        wr(5'h10, 32'h0F);
        settle;
        chk(pad_oe_o, 32'hFFFF_FFFF);
        chk(pad_o, lat);
        chk(pullup_en_o, lat & ~32'h0000_F000);
        chk(router_eligible_o, ~32'h0000_F000);
        rdc(5'h0C, lat & ~32'h0000_F000);
        rdc(5'h14, lat & ~32'h0000_F000);
        rdc(5'h18, lat);
        rdc(5'h10, 32'h0F);
        wr(5'h00, 32'hC2);
        settle;
        chk(pullup_en_o, 32'h0);
        chk(router_eligible_o, ~32'h0000_F0C0);
        wr(5'h00, 32'h43);
        settle;
        chk(router_eligible_o, ~32'h0000_F0E0);
    endtask
    task memif_scn;
        periph_in_assign_i <= 32'h3;
        periph_out_en_i <= 32'h00FF_0000;
        periph_out_i <= 32'h005A_0000;
        memif_pin_en_i <= 32'hFF0F_00E0;
        memif_out_i <= 32'h0000_00A0;
        memif_active_i <= 1'b1;
        settle;
        chk(pad_oe_o, ~32'h3);
        chk(pad_o & ~32'h3, (32'h0050_00A0 | (lat & 32'h0000_FF1C)));
        memif_read_i <= 1'b1;
        settle;
        chk(pad_oe_o, ~32'h3 & ~ppc_pkg::DATA_BUS_MASK);
        memif_active_i <= 1'b0;
        memif_read_i <= 1'b0;
        settle;
        chk(pad_oe_o, ~32'h3);
        rdc(5'h01, 32'h0);
    endtask
    task wrap_up;
        $display("Checks %0d, errors %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #40000;
        fails++;
        wrap_up;
    end
    // Main sequence
    initial begin
        {nrst_i, avs_read_i, avs_write_i, memif_active_i, memif_read_i} = 5'h0;
        {avs_address_i, avs_writedata_i, ext_en, memif_pin_en_i, memif_out_i} = '0;
        {periph_out_en_i, periph_out_i, periph_in_assign_i} = '0;
        avs_byteenable_i = 4'hF;
        ext_val = 32'hFFFF_FFFF;
        fails = 0;
        checked = 0;
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        chk(pullup_en_o, 32'hFFFF_FFFF);
        rdc(5'h18, 32'hFFFF_FFFF);
        rdc(5'h08, 32'h0);
        irq_scn;
        pin_scn;
        memif_scn;
        wrap_up;
    end
endmodule
